// [verilog/bccl_top.v]
// breaker coil control logic with apb register slave
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "bccl_consts.vh"
//
// Contract
// - no coil operation without auxiliary power
// - start only with enough stored energy
// - switch only from defined limit position
// - close coil only from open, energy ok
// - open coil only from closed, energy ok
// - simultaneous open beats close
// - close block stops closing, not opening
// - held close plus open: one cycle only
// - reclose needs close released then reasserted
// - coil off once target position reached
// - energy need depends on present position
// - remote contacts and pushbuttons both command
// - position comes from two proximity sensors
// - implausible sensor pair flags system fault
// - timing covers 55 ms close, 40 ms open
// - drive ready indicator output
// - watch capacitor level continuously
// - ignore close while truck between positions
module bccl_top #(
    parameter [31:0] COIL_TMO_CYC = `BCCL_COIL_TMO_CYC,  // coil supervision timeout
    parameter [31:0] SENS_TMO_CYC = `BCCL_SENS_TMO_CYC   // sensor disagreement timeout
) (
    input  wire        core_clk_in,
    input  wire        reset_n_in,
    input  wire        aux_power_ok_in,        // converter supply present
    input  wire        energy_close_open_in,   // capacitor covers close plus open
    input  wire        energy_open_in,         // capacitor covers one open
    input  wire        sens_open_in,           // open limit proximity sensor
    input  wire        sens_closed_in,         // closed limit proximity sensor
    input  wire        remote_close_in,        // remote momentary close contact
    input  wire        remote_open_in,         // remote momentary open contact
    input  wire        pb_close_in,            // front panel close button
    input  wire        pb_open_in,             // front panel open button
    input  wire        close_block_in,         // external close block
    input  wire        truck_in_position_in,   // truck at a positive rack position
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         close_coil_out,         // close coil drive
    output reg         open_coil_out,          // open coil drive
    output reg         ready_out,              // switching readiness lamp
    output reg         op_fault_out,           // operation fault latched
    output reg         sens_fault_out          // sensor fault latched
);

    // ************************************************************
    // input synchronisers: three stages, change on stages 2/3 agree
    // ************************************************************
    localparam NIN = 11;
    wire [NIN-1:0] raw_in = {truck_in_position_in, close_block_in, pb_open_in, pb_close_in,
                             remote_open_in, remote_close_in, sens_closed_in, sens_open_in,
                             energy_open_in, energy_close_open_in, aux_power_ok_in};
    reg  [NIN-1:0] s1_reg;      // first stage, read only by s2
    reg  [NIN-1:0] s2_reg;      // second stage
    reg  [NIN-1:0] s3_reg;      // third stage
    reg  [NIN-1:0] filt_reg;    // accepted level
    // a bit may change only while stages two and three agree
    wire [NIN-1:0] agree = ~(s2_reg ^ s3_reg);
    // sample the pins into three stages and filter
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            s1_reg   <= {NIN{1'b0}};
            s2_reg   <= {NIN{1'b0}};
            s3_reg   <= {NIN{1'b0}};
            filt_reg <= {NIN{1'b0}};
        end else begin
            s1_reg   <= raw_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            // take stage three where it agrees, else hold
            filt_reg <= (filt_reg & ~agree) | (s3_reg & agree);
        end
    end

    // filtered condition and position flags
    wire aux_ok   = filt_reg[0];                 // auxiliary power present
    wire en_co    = filt_reg[1];                 // energy for close plus open
    wire en_o     = filt_reg[2];                 // energy for one open
    wire is_open  = filt_reg[3] & ~filt_reg[4];
    wire is_closd = filt_reg[4] & ~filt_reg[3];
    wire truck_ok = filt_reg[10];                // truck at a rack position

    // ************************************************************
    // shared helpers
    // ************************************************************
    // one-step increment used by the coil and sensor timers
    function [31:0] cnt_inc;
        input [31:0] value;  // present count
        begin
            cnt_inc = value + 32'h0000_0001;
        end
    endfunction

    // one-hot register select: ctrl, status, timeout; zero if unmapped
    function [2:0] reg_sel;
        input [11:0] addr;  // apb byte address
        begin
            if (addr == `BCCL_OFS_CTRL) begin
                reg_sel = 3'b001;
            end else if (addr == `BCCL_OFS_STATUS) begin
                reg_sel = 3'b010;
            end else if (addr == `BCCL_OFS_TIMEOUT) begin
                reg_sel = 3'b100;
            end else begin
                reg_sel = 3'b000;
            end
        end
    endfunction

    // ************************************************************
    // apb registers
    // ************************************************************
    reg        sw_close_reg;   // software close pulse
    reg        sw_open_reg;    // software open pulse
    reg        flt_clr_reg;    // fault clear pulse
    reg [31:0] tmo_reg;        // coil timeout in cycles

    // apb strobes: access completes when pready is sampled high
    wire       apb_acc = psel & penable & pready;  // transfer taken
    wire       apb_wr  = apb_acc & pwrite;         // write taken
    wire [2:0] sel     = reg_sel(paddr);           // decoded register

    // command merge: remote contacts, buttons, software
    wire close_cmd = filt_reg[5] | filt_reg[7] | sw_close_reg;
    wire open_cmd  = filt_reg[6] | filt_reg[8] | sw_open_reg;

    // ************************************************************
    // coil state machine, one-hot
    // ************************************************************
    // one-hot coil states
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_CLOSE = 3'b010;
    localparam [2:0] ST_OPEN  = 3'b100;
    // state and supervision registers
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [31:0] coil_cnt_reg;      // cycles the coil has been on
    reg [31:0] sens_cnt_reg;      // idle cycles sensors show no limit
    reg        close_armed_reg;   // close seen released since last close
    reg        op_fault_reg;
    reg        sens_fault_reg;

    // energy need depends on present position
    wire energy_ok = is_open ? en_co : (is_closd ? en_o : 1'b0);
    wire healthy   = aux_ok & ~op_fault_reg & ~sens_fault_reg;
    wire can_close = healthy & is_open & en_co & truck_ok & ~filt_reg[9]
                     & close_cmd & ~open_cmd & close_armed_reg;
    wire can_open  = healthy & is_closd & en_o & open_cmd;
    wire coil_tmo  = (coil_cnt_reg >= tmo_reg);

    // next state logic
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (can_open) begin
                    state_next = ST_OPEN;
                end else if (can_close) begin
                    state_next = ST_CLOSE;
                end
            end
            ST_CLOSE: begin
                if (is_closd || coil_tmo || !aux_ok) begin
                    state_next = ST_IDLE;
                end
            end
            ST_OPEN: begin
                if (is_open || coil_tmo || !aux_ok) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state, counters, anti-pumping and faults
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state_reg       <= ST_IDLE;
            coil_cnt_reg    <= 32'h0000_0000;
            sens_cnt_reg    <= 32'h0000_0000;
            close_armed_reg <= 1'b0;
            op_fault_reg    <= 1'b0;
            sens_fault_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            // coil on-time count
            if (state_reg == ST_IDLE) begin
                coil_cnt_reg <= 32'h0000_0000;
            end else begin
                coil_cnt_reg <= cnt_inc(coil_cnt_reg);
            end
            // anti-pumping: disarm on close start, rearm on release
            if (state_reg == ST_IDLE && state_next == ST_CLOSE) begin
                close_armed_reg <= 1'b0;
            end else if (!close_cmd) begin
                close_armed_reg <= 1'b1;
            end
            // operation fault: set wins over clear
            if (state_reg != ST_IDLE && coil_tmo && !(is_open && state_reg == ST_OPEN)
                && !(is_closd && state_reg == ST_CLOSE)) begin
                op_fault_reg <= 1'b1;
            end else if (flt_clr_reg) begin
                op_fault_reg <= 1'b0;
            end
            // sensor plausibility: both on, or neither beyond travel time
            if (filt_reg[3] && filt_reg[4]) begin
                sens_cnt_reg <= SENS_TMO_CYC;
            end else if (is_open || is_closd) begin
                sens_cnt_reg <= 32'h0000_0000;
            end else if (state_reg == ST_IDLE && sens_cnt_reg < SENS_TMO_CYC) begin
                sens_cnt_reg <= cnt_inc(sens_cnt_reg);
            end
            if (sens_cnt_reg >= SENS_TMO_CYC) begin
                sens_fault_reg <= 1'b1;
            end else if (flt_clr_reg) begin
                sens_fault_reg <= 1'b0;
            end
        end
    end

    // registered outputs
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            close_coil_out <= 1'b0;
            open_coil_out  <= 1'b0;
            ready_out      <= 1'b0;
            op_fault_out   <= 1'b0;
            sens_fault_out <= 1'b0;
        end else begin
            close_coil_out <= (state_next == ST_CLOSE);
            open_coil_out  <= (state_next == ST_OPEN);
            ready_out      <= healthy & (is_open | is_closd) & energy_ok;
            // fault flags mirrored from their latches
            op_fault_out   <= op_fault_reg;
            sens_fault_out <= sens_fault_reg;
        end
    end

    // ************************************************************
    // apb slave, one wait state per access
    // ************************************************************
    // status word, one bit per condition
    wire [31:0] status_word = {22'h000000, close_armed_reg, energy_ok, aux_ok,
                               open_coil_out, close_coil_out, sens_fault_reg,
                               op_fault_reg, ready_out, is_closd, is_open};

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h0000_0000;
            sw_close_reg <= 1'b0;
            sw_open_reg  <= 1'b0;
            flt_clr_reg  <= 1'b0;
            tmo_reg      <= COIL_TMO_CYC;
        end else begin
            // command bits are single-cycle pulses
            sw_close_reg <= 1'b0;
            sw_open_reg  <= 1'b0;
            flt_clr_reg  <= 1'b0;
            pready       <= psel & penable & ~pready;
            pslverr      <= 1'b0;
            if (psel && penable && !pready) begin
                // address decode
                if (sel[0]) begin
                    prdata <= 32'h0000_0000;
                end else if (sel[1]) begin
                    prdata <= status_word;
                end else if (sel[2]) begin
                    prdata <= tmo_reg;
                end else begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            end
            if (apb_wr) begin
                if (sel[0]) begin
                    flt_clr_reg  <= pwdata[`BCCL_CTRL_FLT_CLR];
                    sw_open_reg  <= pwdata[`BCCL_CTRL_SW_OPEN];
                    sw_close_reg <= pwdata[`BCCL_CTRL_SW_CLOSE];
                end else if (sel[2]) begin
                    tmo_reg <= pwdata;
                end
            end
        end
    end

endmodule // bccl_top

// [include/bccl_consts.vh]
// constants for the breaker coil control logic
`ifndef BCCL_CONSTS_VH
`define BCCL_CONSTS_VH

// ************************************************************
// apb register offsets (byte addresses)
// ************************************************************
`define BCCL_OFS_CTRL     12'h000
`define BCCL_OFS_STATUS   12'h004
`define BCCL_OFS_TIMEOUT  12'h008

// ************************************************************
// field positions
// ************************************************************
`define BCCL_CTRL_FLT_CLR   0
`define BCCL_CTRL_SW_OPEN   1
`define BCCL_CTRL_SW_CLOSE  2
`define BCCL_ST_IS_OPEN     0
`define BCCL_ST_IS_CLOSED   1
`define BCCL_ST_READY       2
`define BCCL_ST_OP_FAULT    3
`define BCCL_ST_SENS_FAULT  4
`define BCCL_ST_CLOSE_COIL  5
`define BCCL_ST_OPEN_COIL   6
`define BCCL_ST_AUX_OK      7
`define BCCL_ST_ENERGY_OK   8
`define BCCL_ST_CLOSE_ARMED 9

// ************************************************************
// timing: 20 mhz clock, times in ms
// ************************************************************
`define BCCL_CLK_KHZ          20
`define BCCL_CLOSE_TRAVEL_MS  55
`define BCCL_OPEN_TRAVEL_MS   40
`define BCCL_TRAVEL_MARGIN    3
// default coil timeout covers margin times the longer travel
`define BCCL_COIL_TMO_CYC     (`BCCL_CLOSE_TRAVEL_MS * `BCCL_CLK_KHZ * 1000 * `BCCL_TRAVEL_MARGIN)
// sensor disagreement longer than margin times the open travel flags a fault
`define BCCL_SENS_TMO_CYC     (`BCCL_OPEN_TRAVEL_MS * `BCCL_CLK_KHZ * 1000 * `BCCL_TRAVEL_MARGIN)

`endif

// [tb/bccl_top_properties.sv]
// concurrent checks on the coil control ports
`timescale 1ns/100ps
module bccl_top_properties #(
    parameter [31:0] COIL_TMO_CYC = 32'h0000_00c8  // coil timeout in cycles
) (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire aux_power_ok_in,
    input wire energy_open_in,
    input wire sens_closed_in,
    input wire close_block_in,
    input wire truck_in_position_in,
    input wire close_coil_out,
    input wire open_coil_out,
    input wire ready_out,
    input wire sens_fault_out
);
    // ********
    // coil checks
    // ********
    int on_cnt;  // cycles the close coil has stood
    always @(posedge core_clk_in) on_cnt <= (!reset_n_in || !close_coil_out) ? 0 : on_cnt + 1;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    coil_excl_a: assert property (!(close_coil_out && open_coil_out))
        else $error("both coils on");
    aux_loss_a: assert property ((!aux_power_ok_in)[*8] |-> !close_coil_out && !open_coil_out)
        else $error("coil without power");
    close_ready_a: assert property ($rose(close_coil_out) |-> $past(ready_out))
        else $error("close while not ready");
    close_block_a: assert property (close_block_in[*8] |-> !$rose(close_coil_out))
        else $error("close while blocked");
    truck_out_a: assert property ((!truck_in_position_in)[*8] |-> !$rose(close_coil_out))
        else $error("close with truck out");
    close_target_a: assert property (sens_closed_in[*8] |-> !close_coil_out)
        else $error("close coil held at limit");
    open_energy_a: assert property ((!energy_open_in)[*8] |-> !$rose(open_coil_out))
        else $error("open without energy");
    sens_pair_a: assert property ((sens_closed_in && ready_out)[*8] |-> !sens_fault_out)
        else $error("fault at good limit");
    coil_bound_a: assert property (on_cnt <= COIL_TMO_CYC + 8)
        else $error("close coil overran");
    cover property ($rose(close_coil_out));  // close operation
    cover property ($rose(open_coil_out));  // open operation
    cover property ($rose(sens_fault_out));  // sensor fault
endmodule  // bccl_top_properties
bind bccl_top bccl_top_properties #(.COIL_TMO_CYC(COIL_TMO_CYC)) u_bccl_top_properties (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .aux_power_ok_in(aux_power_ok_in),
    .energy_open_in(energy_open_in), .sens_closed_in(sens_closed_in), .close_block_in(close_block_in),
    .truck_in_position_in(truck_in_position_in), .close_coil_out(close_coil_out),
    .open_coil_out(open_coil_out), .ready_out(ready_out), .sens_fault_out(sens_fault_out));

// [tb/bccl_mech_model.sv]
// behavioural breaker mechanism driving the two limit sensors
`timescale 1ns/100ps
module bccl_mech_model #(
    parameter int CLOSE_TRAVEL = 20,  // scaled close travel in cycles
    parameter int OPEN_TRAVEL  = 15   // scaled open travel in cycles
) (
    input  wire logic core_clk_in,
    input  wire logic reset_n_in,
    input  wire logic close_coil_in,    // close coil drive
    input  wire logic open_coil_in,     // open coil drive
    input  wire logic stall_in,         // jammed armature
    input  wire logic both_in,          // broken sensor pair
    output logic      sens_open_out,    // open limit sensor
    output logic      sens_closed_out   // closed limit sensor
);
    // ********
    // armature travel
    // ********
    logic closed_reg;  // armature latched closed
    int   trv_cnt;     // cycles of travel so far
    logic drive;       // coil pushes away from present limit
    assign drive = closed_reg ? open_coil_in : close_coil_in;
    always @(posedge core_clk_in) begin
        if (!reset_n_in || !drive || stall_in) begin
            trv_cnt <= 0;  // no travel
        end else if (trv_cnt == (closed_reg ? OPEN_TRAVEL : CLOSE_TRAVEL) - 1) begin
            trv_cnt    <= 0;
            closed_reg <= ~closed_reg;
        end else begin
            trv_cnt <= trv_cnt + 1;
        end
        if (!reset_n_in && closed_reg === 1'bx) closed_reg <= 1'b0;  // power-up open
    end
    // both sensors dark in mid travel
    assign sens_open_out   = both_in | (!closed_reg && trv_cnt == 0);
    assign sens_closed_out = both_in | (closed_reg && trv_cnt == 0);
endmodule  // bccl_mech_model

// [tb/bccl_top_tb_top.sv]
// self-checking testbench for the breaker coil control logic
`timescale 1ns/100ps
module bccl_top_tb_top;
    typedef struct packed {
        logic [4:0] cnd;  // aux, energy c+o, energy o, block, truck
        logic [3:0] cmd;  // pb open, pb close, remote open, remote close
        logic [1:0] exp;  // close seen, open seen
    } bccl_row_t;
    logic        core_clk_in, reset_n_in, stall, both, aux, eco, eo, blk, trk, rc, ro, pbc, pbo, pos;
    logic        psel, penable, pwrite, pready, pslverr, ccoil, ocoil, rdy, opf, snf, sop, scl, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors, total_checks, n_cl, n_op, c0, o0;
    bccl_row_t   rows [10];
    bccl_top #(.COIL_TMO_CYC(32'h0000_00c8), .SENS_TMO_CYC(32'h0000_012c)) u_bccl_top (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .aux_power_ok_in(aux),
        .energy_close_open_in(eco), .energy_open_in(eo), .sens_open_in(sop), .sens_closed_in(scl),
        .remote_close_in(rc), .remote_open_in(ro), .pb_close_in(pbc), .pb_open_in(pbo),
        .close_block_in(blk), .truck_in_position_in(trk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .close_coil_out(ccoil), .open_coil_out(ocoil), .ready_out(rdy),
        .op_fault_out(opf), .sens_fault_out(snf));
    bccl_mech_model u_bccl_mech_model (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .close_coil_in(ccoil), .open_coil_in(ocoil), .stall_in(stall), .both_in(both),
        .sens_open_out(sop), .sens_closed_out(scl));
    // ********
    // clock, counters, tasks
    // ********
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin  // count coil operations
        if ($rose(ccoil)) n_cl++;
        if ($rose(ocoil)) n_op++;
    end
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk_in);
        psel   <= 1'b1;  // setup cycle
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge core_clk_in);
        penable <= 1'b1;  // access phase
        do @(posedge core_clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] c, input int len);  // momentary command
        {pbo, pbc, ro, rc} <= c;
        repeat (len) @(posedge core_clk_in);
        {pbo, pbc, ro, rc} <= 4'h0;
        repeat (60) @(posedge core_clk_in);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin  // watchdog
        repeat (20000) @(posedge core_clk_in);
        num_errors++;
        end_of_test();
    end
    // ********
    // main sequence
    // ********
    initial begin
        {psel, penable, pwrite, paddr, pwdata, reset_n_in, pos} = '0;
        {aux, eco, eo, blk, trk, rc, ro, pbc, pbo, stall, both} = 11'h740;
        rows = '{'{5'h1d, 4'h1, 2'h2}, '{5'h1d, 4'h1, 2'h0}, '{5'h1d, 4'h8, 2'h1}, '{5'h1f, 4'h1, 2'h0},
                 '{5'h1c, 4'h1, 2'h0}, '{5'h15, 4'h1, 2'h0}, '{5'h0d, 4'h4, 2'h0}, '{5'h1d, 4'h4, 2'h2},
                 '{5'h11, 4'h2, 2'h0}, '{5'h15, 4'h2, 2'h1}};
        repeat (20) @(posedge core_clk_in);
        chk_bit(ccoil | ocoil | rdy | opf | snf, 1'b0);
        reset_n_in <= 1'b1;
        foreach (rows[i]) begin  // one command per row
            {aux, eco, eo, blk, trk} <= rows[i].cnd;
            repeat (10) @(posedge core_clk_in);
            chk_bit(rdy, rows[i].cnd[4] & (pos ? rows[i].cnd[2] : rows[i].cnd[3]));
            c0 = n_cl;
            o0 = n_op;
            pulse(rows[i].cmd, 20);
            chk_word(n_cl - c0, {31'h0, rows[i].exp[1]});
            chk_word(n_op - o0, {31'h0, rows[i].exp[0]});
            pos = pos ^ (|rows[i].exp);
            chk_bit(scl, pos);
        end
        {aux, eco, eo, blk, trk} <= 5'h1d;  // full energy again
        repeat (10) @(posedge core_clk_in);
        c0 = n_cl;  // close held, open follows
        o0 = n_op;
        rc <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        ro <= 1'b1;
        repeat (20) @(posedge core_clk_in);
        ro <= 1'b0;
        repeat (60) @(posedge core_clk_in);
        pulse(4'h0, 1);
        chk_word(n_cl - c0, 32'h1);
        chk_word(n_op - o0, 32'h1);
        c0 = n_cl;  // open and close together
        pulse(4'h3, 20);
        chk_word(n_cl - c0, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk_word(rd, 32'h0000_00c8);
        apb(1'b1, 12'h008, 32'h0000_0064);
        apb(1'b0, 12'h008, 32'h0);
        chk_word(rd, 32'h0000_0064);
        apb(1'b0, 12'hffc, 32'h0);
        chk_word({rd[30:0], err}, 32'h1);
        stall <= 1'b1;  // jammed close
        pulse(4'h1, 20);
        for (int k = 0; k < 100 && opf !== 1'b1; k++) @(posedge core_clk_in);
        chk_bit(opf, 1'b1);
        chk_bit(ccoil, 1'b0);
        stall <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk_bit(opf, 1'b0);
        chk_bit(rd[0], 1'b1);
        c0 = n_cl;  // software close then open
        o0 = n_op;
        apb(1'b1, 12'h000, 32'h0000_0004);
        repeat (40) @(posedge core_clk_in);
        chk_word(n_cl - c0, 32'h1);
        chk_bit(scl, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_0002);
        repeat (40) @(posedge core_clk_in);
        chk_word(n_op - o0, 32'h1);
        chk_bit(sop, 1'b1);
        both <= 1'b1;  // both sensors lit
        repeat (10) @(posedge core_clk_in);
        chk_bit(snf, 1'b1);
        chk_bit(rdy, 1'b0);
        end_of_test();
    end
endmodule  // bccl_top_tb_top
